// ==== rtl/itb_cfg.svh ====
// Register map, reset values and timing constants of the interrupt and time base unit
`ifndef ITB_CFG_SVH
`define ITB_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define ITB_IDX_EN_MAIN 10'h00a
`define ITB_IDX_FLAG_MAIN 10'h00b
`define ITB_IDX_EN_EXT 10'h00c
`define ITB_IDX_FLAG_EXT 10'h00d
`define ITB_IDX_EN_TOUCH 10'h00e
`define ITB_IDX_FLAG_TOUCH 10'h00f
`define ITB_IDX_TB_CTRL 10'h20a
`define ITB_IDX_TRIG_SEL 10'h20c
`define ITB_IDX_ADJ_STAT 10'h219
`define ITB_IDX_PRELOAD_LO 10'h21a
`define ITB_IDX_PRELOAD_HI 10'h21b
`define ITB_IDX_WDT_CLEAR 10'h21d
`define ITB_IDX_SERVICE 10'h21e

// Field positions
`define ITB_BIT_TICK1 0
`define ITB_BIT_TIMER_A 1
`define ITB_BIT_TIMER_B 2
`define ITB_BIT_TICK2 3
`define ITB_BIT_EXT_A 0
`define ITB_BIT_EXT_B 1
`define ITB_BIT_OVERCHARGE 2
`define ITB_BIT_DUTY_OVF 3
`define ITB_BIT_TICK2_SEL 3
`define ITB_BIT_ADJ_IDLE 0

// Reset values and fixed codes
`define ITB_RST_ENABLE 4'h0
`define ITB_RST_FLAG 4'h0
`define ITB_RST_TB_CTRL 4'hf
`define ITB_RST_TRIG_SEL 4'h0
`define ITB_RST_PRELOAD 8'h80
`define ITB_MASK_EXT 4'h3
`define ITB_MASK_TOUCH 4'hc
`define ITB_ALL_ONES 4'hf
`define ITB_VECTOR 12'h001

// Timing: system clock and peripheral tick clock rates in Hz
`define ITB_CLK_HZ 25000000
`define ITB_TICK_HZ 32000
`define ITB_TICK_DIV (`ITB_CLK_HZ / `ITB_TICK_HZ)

`endif

// ==== rtl/itb_pkg.sv ====
// Types shared by the interrupt and time base unit
`default_nettype none
package itb_pkg;

    typedef enum logic [1:0] {
        ITB_TRIG_LOW = 2'h0,
        ITB_TRIG_FALL = 2'h1,
        ITB_TRIG_RISE = 2'h2,
        ITB_TRIG_BOTH = 2'h3
    } itb_trig_t;

    typedef enum logic [2:0] {
        ITB_ADJ_IDLE = 3'b001,
        ITB_ADJ_WAIT = 3'b010,
        ITB_ADJ_MEAS = 3'b100
    } itb_adj_state_t;

endpackage : itb_pkg
`default_nettype wire

// ==== rtl/itb_top.sv ====
// Interrupt gathering, request flags and adjustable time base behind a Wishbone slave
`include "itb_cfg.svh"
`default_nettype none
module itb_top
    import itb_pkg::*;
#(
    parameter int TICK_DIV = `ITB_TICK_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_irq_a_i,
    input wire logic ext_irq_b_i,
    input wire logic timer_a_ovf_i,
    input wire logic timer_b_ovf_i,
    input wire logic overcharge_i,
    input wire logic duty_overflow_i,
    input wire logic key_wakeup_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    output logic irq_req_o,
    output logic [11:0] irq_vector_o,
    output logic tick1_overflow_o,
    output logic tick2_overflow_o,
    output logic sleep_wake_o,
    output logic stop_wake_o,
    output logic wdt_clear_o
);

    localparam int TICK_W = $clog2(TICK_DIV + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);

    // Bus decode
    logic req;
    logic wr;
    logic [9:0] idx;
    logic [3:0] wdat;
    logic [3:0] rdat;
    logic wr_flag_main, wr_flag_ext, wr_flag_touch;
    logic wr_tb_ctrl;
    logic wr_adj;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[11:2];
    assign wdat = wb_dat_i[3:0];
    assign wr_flag_main = wr && (idx == `ITB_IDX_FLAG_MAIN);
    assign wr_flag_ext = wr && (idx == `ITB_IDX_FLAG_EXT);
    assign wr_flag_touch = wr && (idx == `ITB_IDX_FLAG_TOUCH);
    assign wr_tb_ctrl = wr && (idx == `ITB_IDX_TB_CTRL);
    assign wr_adj = wr && (idx == `ITB_IDX_ADJ_STAT) && wdat[`ITB_BIT_ADJ_IDLE];

    // Control registers
    logic [3:0] en_main_q, en_ext_q, en_touch_q;
    logic [3:0] tb_ctrl_q;
    logic [3:0] trig_sel_q;
    logic [3:0] flag_main_q;
    logic [3:0] flag_ext_q;
    logic [3:0] flag_touch_q;
    logic [7:0] preload_q;
    itb_adj_state_t adj_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_main_q <= `ITB_RST_ENABLE;
            en_ext_q <= `ITB_RST_ENABLE;
            en_touch_q <= `ITB_RST_ENABLE;
            tb_ctrl_q <= `ITB_RST_TB_CTRL;
            trig_sel_q <= `ITB_RST_TRIG_SEL;
        end else if (wr) begin
            case (idx)
                `ITB_IDX_EN_MAIN: en_main_q <= wdat;
                `ITB_IDX_EN_EXT: en_ext_q <= wdat & `ITB_MASK_EXT;
                `ITB_IDX_EN_TOUCH: en_touch_q <= wdat & `ITB_MASK_TOUCH;
                `ITB_IDX_TB_CTRL: tb_ctrl_q <= wdat;
                `ITB_IDX_TRIG_SEL: trig_sel_q <= wdat;
                default: ;
            endcase
        end
    end

    // Bus answer one cycle after the strobe; unmapped indices read zero
    always_comb begin
        case (idx)
            `ITB_IDX_EN_MAIN: rdat = en_main_q;
            `ITB_IDX_FLAG_MAIN: rdat = flag_main_q;
            `ITB_IDX_EN_EXT: rdat = en_ext_q;
            `ITB_IDX_FLAG_EXT: rdat = flag_ext_q;
            `ITB_IDX_EN_TOUCH: rdat = en_touch_q;
            `ITB_IDX_FLAG_TOUCH: rdat = flag_touch_q;
            `ITB_IDX_TB_CTRL: rdat = tb_ctrl_q;
            `ITB_IDX_TRIG_SEL: rdat = trig_sel_q;
            `ITB_IDX_ADJ_STAT: rdat = {3'h0, adj_q == ITB_ADJ_IDLE};
            `ITB_IDX_PRELOAD_LO: rdat = preload_q[3:0];
            `ITB_IDX_PRELOAD_HI: rdat = preload_q[7:4];
            default: rdat = 4'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {28'h0, rdat} : 32'h0;
        end
    end

    // External trigger detection, one lane per input
    logic [1:0] ext_in;
    logic [1:0] ext_prev_q;
    logic [1:0] ext_hit;

    assign ext_in = {ext_irq_b_i, ext_irq_a_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_prev_q <= 2'h3;
        end else begin
            ext_prev_q <= ext_in;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_ext
        always_comb begin
            case (itb_trig_t'(trig_sel_q[2*g+1 -: 2]))
                ITB_TRIG_LOW: ext_hit[g] = !ext_in[g];
                ITB_TRIG_FALL: ext_hit[g] = ext_prev_q[g] && !ext_in[g];
                ITB_TRIG_RISE: ext_hit[g] = !ext_prev_q[g] && ext_in[g];
                ITB_TRIG_BOTH: ext_hit[g] = ext_prev_q[g] ^ ext_in[g];
                default: ext_hit[g] = 1'b0;
            endcase
        end
    end

    // Timer overflow edges
    logic [1:0] tmr_prev_q;
    logic [1:0] tmr_edge;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_prev_q <= 2'h0;
        end else begin
            tmr_prev_q <= {timer_b_ovf_i, timer_a_ovf_i};
        end
    end

    assign tmr_edge = {timer_b_ovf_i, timer_a_ovf_i} & ~tmr_prev_q;

    // Time base: tick enable, preloaded first stage, postscaler
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_en;
    logic [7:0] stage_q;
    logic [7:0] post_q;
    logic stage_ovf;
    logic [7:0] mask1, mask2;
    logic tick1, tick2;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    assign tick_en = (tick_cnt_q == TICK_LAST);
    assign stage_ovf = tick_en && (stage_q == 8'hff) && !wr_tb_ctrl;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= `ITB_RST_PRELOAD;
            post_q <= 8'h00;
        end else if (wr_tb_ctrl) begin
            stage_q <= preload_q;
            post_q <= 8'h00;
        end else if (tick_en) begin
            stage_q <= (stage_q == 8'hff) ? preload_q : stage_q + 8'h01;
            if (stage_ovf) begin
                post_q <= post_q + 8'h01;
            end
        end
    end

    // Nominal stage rate is tick/128, so tick1 is stage/2 up to stage/256
    assign mask1 = ~(8'hfe << tb_ctrl_q[2:0]);
    assign mask2 = tb_ctrl_q[`ITB_BIT_TICK2_SEL] ? 8'h0f : 8'h07;
    assign tick1 = stage_ovf && ((post_q & mask1) == mask1);
    assign tick2 = stage_ovf && ((post_q & mask2) == mask2);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick1_overflow_o <= 1'b0;
            tick2_overflow_o <= 1'b0;
        end else begin
            tick1_overflow_o <= tick1;
            tick2_overflow_o <= tick2;
        end
    end

    // Request flags; a set in the clearing cycle survives
    logic [3:0] set_main, set_ext, set_touch;

    assign set_main = {tick2, tmr_edge[1], tmr_edge[0], tick1};
    assign set_ext = {2'h0, ext_hit};
    assign set_touch = {duty_overflow_i, overcharge_i, 2'h0};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_main_q <= `ITB_RST_FLAG;
            flag_ext_q <= `ITB_RST_FLAG;
            flag_touch_q <= `ITB_RST_FLAG;
        end else begin
            flag_main_q <= (flag_main_q & (wr_flag_main ? wdat : `ITB_ALL_ONES))
                | set_main;
            flag_ext_q <= (flag_ext_q & (wr_flag_ext ? wdat : `ITB_ALL_ONES))
                | set_ext;
            flag_touch_q <= (flag_touch_q & (wr_flag_touch ? wdat : `ITB_ALL_ONES))
                | set_touch;
        end
    end

    // Frequency adjustment: count ticks in one reference period
    logic [8:0] meas_q;
    logic ref_edge;

    assign ref_edge = tmr_edge[1];

    function automatic logic [7:0] itb_preload_of(input logic [8:0] ticks);
        logic [8:0] diff;
        diff = 9'h100 - ticks;
        if (ticks == 9'h000) begin
            itb_preload_of = 8'hff;
        end else begin
            itb_preload_of = diff[7:0];
        end
    endfunction : itb_preload_of

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adj_q <= ITB_ADJ_IDLE;
            meas_q <= 9'h000;
            preload_q <= `ITB_RST_PRELOAD;
        end else begin
            case (adj_q)
                ITB_ADJ_IDLE: begin
                    if (wr_adj) begin
                        adj_q <= ITB_ADJ_WAIT;
                    end
                end
                ITB_ADJ_WAIT: begin
                    meas_q <= 9'h000;
                    if (ref_edge) begin
                        adj_q <= ITB_ADJ_MEAS;
                    end
                end
                ITB_ADJ_MEAS: begin
                    if (ref_edge) begin
                        preload_q <= itb_preload_of(meas_q);
                        adj_q <= ITB_ADJ_IDLE;
                    end else if (tick_en && meas_q != 9'h100) begin
                        meas_q <= meas_q + 9'h001;
                    end
                end
                default: adj_q <= ITB_ADJ_IDLE;
            endcase
        end
    end

    // Service request; no priority, software polls the flags
    logic [3:0] pend;
    logic in_service_q;

    assign pend = {|(en_touch_q & flag_touch_q), |(en_ext_q & flag_ext_q),
        |(en_main_q & flag_main_q), 1'b0};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_service_q <= 1'b0;
        end else if (irq_return_i) begin
            in_service_q <= 1'b0;
        end else if (irq_ack_i) begin
            in_service_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_o <= 1'b0;
            irq_vector_o <= `ITB_VECTOR;
        end else begin
            irq_req_o <= !in_service_q && !irq_ack_i && (|pend);
            irq_vector_o <= `ITB_VECTOR;
        end
    end

    // Wake-up: stop mode only sees external sources and keys
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_wake_o <= 1'b0;
            stop_wake_o <= 1'b0;
        end else begin
            sleep_wake_o <= (|pend) || key_wakeup_i;
            stop_wake_o <= (|(en_ext_q & flag_ext_q)) || key_wakeup_i;
        end
    end

    // Two-step watchdog clear; any other write in between disarms it
    logic wdt_arm_q;
    logic wr_wdt;

    assign wr_wdt = wr && (idx == `ITB_IDX_WDT_CLEAR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_arm_q <= 1'b0;
            wdt_clear_o <= 1'b0;
        end else begin
            wdt_clear_o <= wr_wdt && wdt_arm_q;
            if (wr) begin
                wdt_arm_q <= wr_flag_main && (wdat == `ITB_ALL_ONES);
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_adj_start;
        (adj_q == ITB_ADJ_IDLE) && wr_adj;
    endsequence
    sequence s_wdt_armed_clear;
        wr_flag_main && (wdat == `ITB_ALL_ONES) ##[2:20] (wr_wdt && wdt_arm_q);
    endsequence
    vector_fixed_a: assert property (irq_vector_o == `ITB_VECTOR)
        else $error("vector moved");
    service_hold_a: assert property (in_service_q |=> !irq_req_o)
        else $error("request raised during service");
    request_raise_a: assert property (!in_service_q && !irq_ack_i && (|pend)
        |=> irq_req_o)
        else $error("pending request not raised");
    one_ignored_a: assert property (wr_flag_main && wdat == `ITB_ALL_ONES
        && set_main == 4'h0 |=> flag_main_q == $past(flag_main_q))
        else $error("writing ones changed a flag");
    ext_level_a: assert property (trig_sel_q[1:0] == 2'h0 && !ext_irq_a_i
        |=> flag_ext_q[`ITB_BIT_EXT_A])
        else $error("low level did not set flag");
    ext_fall_a: assert property (trig_sel_q[1:0] == 2'h1 && $fell(ext_irq_a_i)
        && !wr_flag_ext |=> flag_ext_q[`ITB_BIT_EXT_A])
        else $error("falling edge missed");
    timer_edge_a: assert property ($rose(timer_a_ovf_i) |=> flag_main_q[`ITB_BIT_TIMER_A])
        else $error("timer edge missed");
    set_wins_a: assert property (wr_flag_main && !wdat[`ITB_BIT_TIMER_B] && tmr_edge[1]
        |=> flag_main_q[`ITB_BIT_TIMER_B])
        else $error("clear beat set");
    tb_restart_a: assert property (wr_tb_ctrl |=> stage_q == preload_q && post_q == 8'h00)
        else $error("divider not restarted");
    adj_busy_a: assert property (s_adj_start |=> adj_q == ITB_ADJ_WAIT)
        else $error("adjust not busy after start");
    wdt_clear_a: assert property (s_wdt_armed_clear |=> wdt_clear_o ##1 !wdt_clear_o)
        else $error("watchdog clear not issued");

endmodule : itb_top
`default_nettype wire

// ==== sim/itb_cpu_model.sv ====
// CPU core stand-in that enters and leaves interrupt service
`default_nettype none
module itb_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [11:0] vector_i,
    output logic ack_o,
    output logic ret_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int busy_cnt;
    int acks;
    int held_err;
    logic [11:0] last_vec;
    // Service routine lasts 40 cycles; a request seen after its first cycle is counted
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            ret_o <= 1'b0;
            busy_cnt <= 0;
            acks <= 0;
            held_err <= 0;
        end else if (busy_cnt != 0) begin
            ack_o <= 1'b0;
            ret_o <= (busy_cnt == 1);
            busy_cnt <= busy_cnt - 1;
            if (busy_cnt < 40 && req_i) begin
                held_err <= held_err + 1;
            end
        end else begin
            ack_o <= req_i && !ret_o;
            ret_o <= 1'b0;
            if (req_i && !ret_o) begin
                busy_cnt <= 40;
                acks <= acks + 1;
                last_vec <= vector_i;
            end
        end
    end
endmodule : itb_cpu_model
`default_nettype wire

// ==== sim/test_interrupt_and_time_base_unit.sv ====
// Self-checking bench for the interrupt and time base unit
`include "itb_cfg.svh"
`default_nettype none
module test_interrupt_and_time_base_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, w;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, dat_o, rd, d;
    logic ext_a = 1'b1, ext_b = 1'b1, tmr_a = 1'b0, tmr_b = 1'b0;
    logic ovc = 1'b0, duty = 1'b0, key = 1'b0, irq_ack, irq_ret;
    logic req, t1, t2, swk, stw, wdt;
    logic [11:0] vec;
    int err_total = 0, total_checks = 0, seed = 32'hff9c2569, acks0, f, c, n;
    logic [9:0] ridx [12] = '{10'h00a, 10'h00b, 10'h00c, 10'h00d, 10'h00e, 10'h00f,
        10'h20a, 10'h20c, 10'h219, 10'h21a, 10'h21b, 10'h21e};
    logic [31:0] rexp [12] = '{0, 0, 0, 0, 0, 0, 32'hf, 0, 32'h1, 0, 32'h8, 0};
    logic [9:0] eidx [3] = '{`ITB_IDX_EN_MAIN, `ITB_IDX_EN_EXT, `ITB_IDX_EN_TOUCH};
    logic [31:0] emask [3] = '{32'hf, 32'h3, 32'hc};

    always #20 clk_i = ~clk_i;

    itb_top #(.TICK_DIV(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .ext_irq_a_i(ext_a), .ext_irq_b_i(ext_b),
        .timer_a_ovf_i(tmr_a), .timer_b_ovf_i(tmr_b), .overcharge_i(ovc),
        .duty_overflow_i(duty), .key_wakeup_i(key), .irq_ack_i(irq_ack),
        .irq_return_i(irq_ret), .irq_req_o(req), .irq_vector_o(vec),
        .tick1_overflow_o(t1), .tick2_overflow_o(t2), .sleep_wake_o(swk),
        .stop_wake_o(stw), .wdt_clear_o(wdt));
    itb_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .vector_i(vec),
        .ack_o(irq_ack), .ret_o(irq_ret));

    function automatic int tick1_cyc(input int s);
        return (4 * 256) << s;
    endfunction : tick1_cyc
    function automatic int tick2_cyc(input int b);
        return b ? 4 * 2048 : 4 * 1024;
    endfunction : tick2_cyc
    // Flag after fall, after clear while low, after rise
    function automatic logic [31:0] ext_exp(input int m, input int s);
        return s == 0 ? (m != 2) : s == 1 ? (m == 0) : (m == 0 || m >= 2);
    endfunction : ext_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] dv);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= wr;
        adr <= {idx, 2'b00};
        wdat <= dv;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = dat_o;
        w = wdt;
        if (k >= 20) err_total++;
        cyc <= 1'b0;
    endtask : bus
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, idx, 32'h0);
        check(rd & m, e);
    endtask : rd_chk
    task automatic pin(input int p, input logic v);
        @(posedge clk_i);
        if (p != 0) ext_b <= v;
        else ext_a <= v;
    endtask : pin
    // Cycles to the first pulse, then between two pulses
    task automatic gap(input logic which, output int fc, output int gc);
        fc = 0;
        gc = 0;
        while ((which ? t2 : t1) !== 1'b1 && fc < 20000) begin
            @(posedge clk_i);
            fc++;
        end
        do begin
            @(posedge clk_i);
            gc++;
        end while ((which ? t2 : t1) !== 1'b1 && gc < 20000);
    endtask : gap
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (90000) @(posedge clk_i);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ridx[i]) rd_chk(ridx[i], 32'hffffffff, rexp[i]);
        bus(1'b1, `ITB_IDX_PRELOAD_LO, $random(seed));
        bus(1'b1, `ITB_IDX_PRELOAD_HI, $random(seed));
        rd_chk(`ITB_IDX_PRELOAD_LO, 32'hffffffff, 32'h0);
        rd_chk(`ITB_IDX_PRELOAD_HI, 32'hffffffff, 32'h8);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            bus(1'b1, eidx[i % 3], d);
            rd_chk(eidx[i % 3], 32'hffffffff, d & emask[i % 3]);
            bus(1'b1, eidx[i % 3], 32'h0);
        end
        bus(1'b1, `ITB_IDX_FLAG_EXT, 32'hf);
        rd_chk(`ITB_IDX_FLAG_EXT, 32'hffffffff, 32'h0);
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                bus(1'b1, `ITB_IDX_TRIG_SEL, m << (2 * p));
                bus(1'b1, `ITB_IDX_FLAG_EXT, 32'h0);
                rd_chk(`ITB_IDX_FLAG_EXT, 32'h3, 32'h0);
                pin(p, 1'b0);
                rd_chk(`ITB_IDX_FLAG_EXT, 32'h3, ext_exp(m, 0) << p);
                bus(1'b1, `ITB_IDX_FLAG_EXT, 32'h0);
                rd_chk(`ITB_IDX_FLAG_EXT, 32'h3, ext_exp(m, 1) << p);
                pin(p, 1'b1);
                rd_chk(`ITB_IDX_FLAG_EXT, 32'h3, ext_exp(m, 2) << p);
            end
        end
        bus(1'b1, `ITB_IDX_EN_TOUCH, 32'hc);
        @(posedge clk_i);
        ovc <= 1'b1;
        duty <= 1'b1;
        @(posedge clk_i);
        ovc <= 1'b0;
        duty <= 1'b0;
        repeat (3) @(posedge clk_i);
        check(swk, 1'b1);
        check(stw, 1'b0);
        rd_chk(`ITB_IDX_FLAG_TOUCH, 32'hffffffff, 32'hc);
        bus(1'b1, `ITB_IDX_FLAG_TOUCH, 32'h0);
        bus(1'b1, `ITB_IDX_EN_TOUCH, 32'h0);
        key <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(stw, 1'b1);
        key <= 1'b0;
        repeat (60) @(posedge clk_i);
        bus(1'b1, `ITB_IDX_EN_MAIN, 32'h6);
        acks0 = i_cpu.acks;
        @(posedge clk_i);
        tmr_a <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(i_cpu.acks, acks0 + 1);
        check(i_cpu.last_vec, `ITB_VECTOR);
        tmr_b <= 1'b1;
        tmr_a <= 1'b0;
        rd_chk(`ITB_IDX_FLAG_MAIN, 32'h6, 32'h6);
        repeat (60) @(posedge clk_i);
        check(i_cpu.acks, acks0 + 2);
        tmr_b <= 1'b0;
        bus(1'b1, `ITB_IDX_FLAG_MAIN, 32'h0);
        repeat (60) @(posedge clk_i);
        check(i_cpu.acks, acks0 + 2);
        check(i_cpu.held_err, 0);
        // Clear write and timer edge land on the same edge
        fork
            bus(1'b1, `ITB_IDX_FLAG_MAIN, 32'h0);
            begin
                @(posedge clk_i);
                tmr_b <= 1'b1;
            end
        join
        rd_chk(`ITB_IDX_FLAG_MAIN, 32'h4, 32'h4);
        tmr_b <= 1'b0;
        bus(1'b1, `ITB_IDX_FLAG_MAIN, 32'h0);
        bus(1'b1, `ITB_IDX_FLAG_MAIN, 32'hf);
        rd_chk(`ITB_IDX_FLAG_MAIN, 32'h6, 32'h0);
        bus(1'b1, `ITB_IDX_WDT_CLEAR, 32'h0);
        check(w, 1'b1);
        bus(1'b1, `ITB_IDX_WDT_CLEAR, 32'h0);
        check(w, 1'b0);
        bus(1'b1, `ITB_IDX_FLAG_MAIN, 32'hf);
        bus(1'b1, `ITB_IDX_EN_EXT, 32'h0);
        bus(1'b1, `ITB_IDX_WDT_CLEAR, 32'h0);
        check(w, 1'b0);
        bus(1'b1, `ITB_IDX_TB_CTRL, 32'h0);
        gap(1'b0, f, c);
        check(f >= 1016 && f <= 1032, 1'b1);
        check(c, tick1_cyc(0));
        gap(1'b1, f, c);
        check(c, tick2_cyc(0));
        bus(1'b1, `ITB_IDX_TB_CTRL, 32'h9);
        gap(1'b0, f, c);
        check(c, tick1_cyc(1));
        gap(1'b1, f, c);
        check(c, tick2_cyc(1));
        rd_chk(`ITB_IDX_FLAG_MAIN, 32'h9, 32'h9);
        bus(1'b1, `ITB_IDX_ADJ_STAT, 32'h1);
        rd_chk(`ITB_IDX_ADJ_STAT, 32'h1, 32'h0);
        // Reference edges 400 cycles apart give 99 ticks
        @(posedge clk_i);
        tmr_b <= 1'b1;
        @(posedge clk_i);
        tmr_b <= 1'b0;
        repeat (399) @(posedge clk_i);
        tmr_b <= 1'b1;
        @(posedge clk_i);
        tmr_b <= 1'b0;
        n = 0;
        do begin
            bus(1'b0, `ITB_IDX_ADJ_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 50);
        check(rd[0], 1'b1);
        rd_chk(`ITB_IDX_PRELOAD_HI, 32'hf, 32'h9);
        complete_run();
    end
endmodule : test_interrupt_and_time_base_unit
`default_nettype wire
